// ### hw/ssp_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_alu (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire ssp_pkg::ssp_op_t i_op,
    input wire logic [31:0] i_first,
    input wire logic [31:0] i_second,
    input wire logic [4:0] i_shift,
    input wire logic [1:0] i_rot,
    input wire logic [3:0] i_first_reg,
    input wire logic [3:0] i_second_reg,
    input wire logic [3:0] i_dest_reg,
    input wire logic i_dest_given,
    input wire logic [3:0] i_flags,
    output logic o_valid,
    output logic [31:0] o_result,
    output logic [3:0] o_dest_reg,
    output logic [3:0] o_flags
);
    import ssp_pkg::*;
    ssp_lane_if lif();
    logic [31:0] next_result;
    logic [31:0] rot;
    logic [31:0] shl;
    logic [31:0] sar;
    logic [4:0] rbits;
    logic is_ext;
    logic [3:0] next_dest;
    ssp_lanes u_lanes (
        .lif(lif)
    );
    assign lif.a = i_first;
    assign lif.b = i_second;
    assign lif.sub = (i_op == SSP_USUB16) || (i_op == SSP_USUB8);
    assign lif.half = (i_op == SSP_UADD16) || (i_op == SSP_USUB16);
    assign rbits = 5'(i_rot * `SSP_ROT_STEP);
    assign rot = (i_second >> rbits) | (i_second << (6'(`SSP_W) - {1'b0, rbits}));
    assign shl = i_second << i_shift;
    // A zero field stands for 32; shifting by 32 yields pure sign copies
    assign sar = (i_shift == 5'h00) ? {32{i_second[31]}}
                                    : 32'($signed(i_second) >>> i_shift);
    assign is_ext = (i_op == SSP_SXB) || (i_op == SSP_UXB) || (i_op == SSP_SXH)
                    || (i_op == SSP_UXH) || (i_op == SSP_SXB16) || (i_op == SSP_UXB16);
    always_comb begin
        next_result = `SSP_RES_RST;
        case (i_op)
            SSP_UADD16, SSP_UADD8, SSP_USUB16, SSP_USUB8: begin
                next_result = lif.y;
            end
            SSP_PKBT: begin
                next_result = {shl[31:16], i_first[15:0]};
            end
            SSP_PKTB: begin
                next_result = {i_first[31:16], sar[15:0]};
            end
            SSP_SXB: begin
                next_result = {{24{rot[7]}}, rot[7:0]};
            end
            SSP_UXB: begin
                next_result = {24'h000000, rot[7:0]};
            end
            SSP_SXH: begin
                next_result = {{16{rot[15]}}, rot[15:0]};
            end
            SSP_UXH: begin
                next_result = {16'h0000, rot[15:0]};
            end
            SSP_SXB16: begin
                next_result = {{8{rot[23]}}, rot[23:16], {8{rot[7]}}, rot[7:0]};
            end
            SSP_UXB16: begin
                next_result = {8'h00, rot[23:16], 8'h00, rot[7:0]};
            end
            default: begin
                next_result = `SSP_RES_RST;
            end
        endcase
    end
    always_comb begin
        next_dest = i_dest_reg;
        if (!i_dest_given) begin
            next_dest = is_ext ? i_second_reg : i_first_reg;
        end
    end
    // Valid only rides along; the stage never stalls or refuses an operation
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_valid <= 1'b0;
        end else begin
            o_valid <= i_valid;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_result <= `SSP_RES_RST;
        end else begin
            o_result <= next_result;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dest_reg <= `SSP_DEST_RST;
        end else begin
            o_dest_reg <= next_dest;
        end
    end
    // Flags only pass through; none of these operations may touch them
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flags <= `SSP_FLAGS_RST;
        end else begin
            o_flags <= i_flags;
        end
    end

    // The edge on which reset lets go still shows reset outputs, so no check starts there
    flags_kept_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op >= SSP_UADD16 && i_op <= SSP_USUB8
        |=> o_flags == $past(i_flags))
        else $error("flags changed by a lane operation");
    flags_pack_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && (i_op == SSP_PKBT || i_op == SSP_PKTB)
        |=> o_flags == $past(i_flags))
        else $error("flags changed by a pack");
    flags_ext_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op >= SSP_SXB && i_op <= SSP_UXB16
        |=> o_flags == $past(i_flags))
        else $error("flags changed by an extend");
    uadd16_lo_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_UADD16 && (17'(i_first[15:0]) + 17'(i_second[15:0])) > 17'h0FFFF
        |=> o_result[15:0] == `SSP_HMAX)
        else $error("halfword add not clamped");
    uadd16_hi_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_UADD16 && (17'(i_first[31:16]) + 17'(i_second[31:16])) < 17'h10000
        |=> o_result[31:16] == 16'($past(i_first[31:16]) + $past(i_second[31:16])))
        else $error("halfword add lost its sum");
    uadd8_b0_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_UADD8 |=> o_result[7:0] ==
        (($past(i_first[7:0]) > ~$past(i_second[7:0])) ? `SSP_BMAX
        : 8'($past(i_first[7:0]) + $past(i_second[7:0])))) else $error("byte add bad");
    uadd8_b3_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_UADD8 && (9'(i_first[31:24]) + 9'(i_second[31:24])) > 9'h0FF
        |=> o_result[31:24] == `SSP_BMAX)
        else $error("top byte add not clamped");

    usub16_hi_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_USUB16 && i_first[31:16] < i_second[31:16]
        |=> o_result[31:16] == 16'h0000)
        else $error("halfword sub not floored");
    usub16_lo_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_USUB16 && i_first[15:0] >= i_second[15:0]
        |=> o_result[15:0] == 16'($past(i_first[15:0]) - $past(i_second[15:0])))
        else $error("halfword sub lost its difference");
    usub8_b3_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_USUB8 && i_first[31:24] >= i_second[31:24]
        |=> o_result[31:24] == 8'($past(i_first[31:24]) - $past(i_second[31:24])))
        else $error("byte sub bad");
    usub8_b0_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_USUB8 && i_first[7:0] < i_second[7:0]
        |=> o_result[7:0] == 8'h00)
        else $error("byte sub not floored");

    pack_bt_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_PKBT |=> o_result[15:0] == $past(i_first[15:0]) &&
        o_result[31:16] == 16'(($past(i_second) << $past(i_shift)) >> `SSP_HW))
        else $error("bottom-top pack bad");
    pack_bt0_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_PKBT && i_shift == 5'h00
        |=> o_result[31:16] == $past(i_second[31:16]))
        else $error("unshifted pack bad");
    pack_tb_top_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_PKTB
        |=> o_result[31:16] == $past(i_first[31:16]))
        else $error("top-bottom pack lost its top");
    pack_tb1_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_PKTB && i_shift == 5'h01
        |=> o_result[15:0] == $past(i_second[16:1]))
        else $error("top-bottom pack shift bad");
    pack_tb32_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_PKTB && i_shift == 5'h00
        |=> o_result[15:0] == {16{$past(i_second[31])}})
        else $error("shift of 32 bad");

    ext_rot_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_UXB && i_rot == 2'h3
        |=> o_result == {24'h000000, $past(i_second[31:24])})
        else $error("extend rotation bad");
    ext_byte_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_SXB && i_rot == 2'h1
        |=> o_result == {{24{$past(i_second[15])}}, $past(i_second[15:8])})
        else $error("byte extend bad");
    ext_half_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_SXH && i_rot == 2'h2
        |=> o_result == {{16{$past(i_second[31])}}, $past(i_second[31:16])})
        else $error("halfword extend bad");
    ext_half_z_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_UXH && i_rot == 2'h0
        |=> o_result == {16'h0000, $past(i_second[15:0])})
        else $error("halfword zero extend bad");
    ext_dual_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_SXB16 && i_rot == 2'h0
        |=> o_result[31:16] == {{8{$past(i_second[23])}}, $past(i_second[23:16])} &&
        o_result[15:0] == {{8{$past(i_second[7])}}, $past(i_second[7:0])})
        else $error("dual byte extend bad");
    ext_dual_z_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_op == SSP_UXB16 && i_rot == 2'h1
        |=> o_result == {8'h00, $past(i_second[31:24]), 8'h00, $past(i_second[15:8])})
        else $error("dual byte zero extend bad");

    dest_default_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && !i_dest_given && !is_ext
        |=> o_dest_reg == $past(i_first_reg))
        else $error("default destination bad");
    dest_ext_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && !i_dest_given && i_op >= SSP_SXB && i_op <= SSP_UXB16
        |=> o_dest_reg == $past(i_second_reg))
        else $error("default extend destination bad");
    dest_given_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_dest_given
        |=> o_dest_reg == $past(i_dest_reg))
        else $error("given destination bad");

    cov_sat_c: cover property (@(posedge i_clk) i_op == SSP_UADD16 && lif.y[15:0] == `SSP_HMAX);
    cov_floor_c: cover property (@(posedge i_clk) i_op == SSP_USUB16 && lif.y[31:16] == 16'h0000);
    cov_tb_c: cover property (@(posedge i_clk) i_op == SSP_PKTB && i_shift == 5'h00);
    cov_ext_c: cover property (@(posedge i_clk) i_op == SSP_SXB16 && i_rot == 2'h3);
    cov_dest_c: cover property (@(posedge i_clk) !i_dest_given && i_op == SSP_UXB16);
endmodule
`default_nettype wire

// ### hw/ssp_lanes.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_lanes (
    ssp_lane_if.core lif
);
    import ssp_pkg::*;
    logic [3:0] bs;
    logic [1:0] hs;
    logic [31:0] bsum;
    logic [31:0] hsum;
    genvar g;
    // Borrow shows as a set top bit, like a carry out, so one saturate test serves add and subtract
    generate
        for (g = 0; g < 4; g++) begin : g_byte
            logic [8:0] t;
            assign t = lif.sub ? {1'b0, lif.a[g*8 +: 8]} - {1'b0, lif.b[g*8 +: 8]}
                               : {1'b0, lif.a[g*8 +: 8]} + {1'b0, lif.b[g*8 +: 8]};
            assign bs[g] = t[8];
            assign bsum[g*8 +: 8] = bs[g] ? (lif.sub ? 8'h00 : `SSP_BMAX) : t[7:0];
        end
        for (g = 0; g < 2; g++) begin : g_half
            logic [16:0] t;
            assign t = lif.sub ? {1'b0, lif.a[g*16 +: 16]} - {1'b0, lif.b[g*16 +: 16]}
                               : {1'b0, lif.a[g*16 +: 16]} + {1'b0, lif.b[g*16 +: 16]};
            assign hs[g] = t[16];
            assign hsum[g*16 +: 16] = hs[g] ? (lif.sub ? 16'h0000 : `SSP_HMAX) : t[15:0];
        end
    endgenerate
    assign lif.y = lif.half ? hsum : bsum;
endmodule
`default_nettype wire

// ### pkg/ssp_defines.svh
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_W 32
`define SSP_HW 16
`define SSP_BW 8
`define SSP_HMAX 16'hFFFF
`define SSP_BMAX 8'hFF
`define SSP_ROT_STEP 8
`define SSP_SH_FULL 6'h20
`define SSP_FLAGS_RST 4'h0
`define SSP_RES_RST 32'h0000_0000
`define SSP_DEST_RST 4'h0
`endif

// ### pkg/ssp_lane_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssp_lane_if;
    logic [31:0] a;
    logic [31:0] b;
    logic sub;
    logic half;
    logic [31:0] y;
    modport core (input a, input b, input sub, input half, output y);
    modport user (output a, output b, output sub, output half, input y);
endinterface
`default_nettype wire

// ### pkg/ssp_pkg.sv
`include "ssp_defines.svh"
package ssp_pkg;
    typedef enum logic [3:0] {
        SSP_NOP = 4'h0,
        SSP_UADD16 = 4'h1,
        SSP_UADD8 = 4'h2,
        SSP_USUB16 = 4'h3,
        SSP_USUB8 = 4'h4,
        SSP_PKBT = 4'h5,
        SSP_PKTB = 4'h6,
        SSP_SXB = 4'h7,
        SSP_UXB = 4'h8,
        SSP_SXH = 4'h9,
        SSP_UXH = 4'hA,
        SSP_SXB16 = 4'hB,
        SSP_UXB16 = 4'hC
    } ssp_op_t;
endpackage

// ### tb/ssp_alu_test.sv
`timescale 1ns/1ps
`default_nettype none
module simd_saturate_pack_extend_alu_test;
    import ssp_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_valid = 1'b0;
    ssp_op_t i_op = SSP_NOP;
    logic [31:0] i_first = 32'h0;
    logic [31:0] i_second = 32'h0;
    logic [4:0] i_shift = 5'h0;
    logic [1:0] i_rot = 2'h0;
    logic i_dest_given = 1'b0;
    logic [3:0] i_first_reg = 4'h3;
    logic [3:0] i_second_reg = 4'h5;
    logic [3:0] i_dest_reg = 4'h9;
    logic [3:0] i_flags = 4'hA;
    logic o_valid;
    logic [31:0] o_result;
    logic [3:0] o_dest_reg;
    logic [3:0] o_flags;
    int bad_count = 0;
    int n_compared = 0;
    always #2.5 i_clk = ~i_clk;
    // All three register numbers step together, so they never coincide
    ssp_alu uut (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid), .i_op(i_op),
        .i_first(i_first), .i_second(i_second), .i_shift(i_shift), .i_rot(i_rot),
        .i_first_reg(i_first_reg), .i_second_reg(i_second_reg), .i_dest_reg(i_dest_reg),
        .i_dest_given(i_dest_given), .i_flags(i_flags), .o_valid(o_valid),
        .o_result(o_result), .o_dest_reg(o_dest_reg), .o_flags(o_flags));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One operation in, result one edge later; flags, valid and registers change every call
    task automatic run(input ssp_op_t op, input logic [31:0] a, input logic [31:0] b,
            input logic [4:0] sh, input logic [1:0] rot, output logic [31:0] r);
        logic dg;
        logic vl;
        logic [3:0] fl;
        logic [3:0] fr;
        logic [3:0] sr;
        logic [3:0] dr;
        logic [3:0] de;
        dg = ~i_dest_given;
        vl = ~i_valid;
        fl = i_flags + 4'h5;
        fr = i_first_reg + 4'h1;
        sr = i_second_reg + 4'h1;
        dr = i_dest_reg + 4'h1;
        @(posedge i_clk);
        i_valid <= vl;
        i_first_reg <= fr;
        i_second_reg <= sr;
        i_dest_reg <= dr;
        i_op <= op;
        i_first <= a;
        i_second <= b;
        i_shift <= sh;
        i_rot <= rot;
        i_dest_given <= dg;
        i_flags <= fl;
        @(posedge i_clk);
        #1;
        r = o_result;
        de = dg ? dr : ((op >= SSP_SXB && op <= SSP_UXB16) ? sr : fr);
        chk("flags", {28'h0, o_flags}, {28'h0, fl});
        chk("dest", {28'h0, o_dest_reg}, {28'h0, de});
        chk("valid", {31'h0, o_valid}, {31'h0, vl});
    endtask
    task automatic s_sat();
        logic [31:0] r;
        run(SSP_UADD16, 32'h8000_0001, 32'h8000_0001, 5'h0, 2'h0, r);
        chk("add16", r, 32'hFFFF_0002);
        run(SSP_UADD16, 32'h0001_FFF0, 32'h0001_0020, 5'h0, 2'h0, r);
        chk("add16 low clamp", r, 32'h0002_FFFF);
        run(SSP_UADD8, 32'h80FF_0102, 32'h8001_7F01, 5'h0, 2'h0, r);
        chk("add8", r, 32'hFFFF_8003);
        run(SSP_USUB16, 32'h0005_1000, 32'h0006_0FFF, 5'h0, 2'h0, r);
        chk("sub16", r, 32'h0000_0001);
        run(SSP_USUB8, 32'h30FF_0001, 32'h2001_0002, 5'h0, 2'h0, r);
        chk("sub8", r, 32'h10FE_0000);
        run(ssp_op_t'(4'hF), 32'h1234_5678, 32'h1234_5678, 5'h0, 2'h0, r);
        chk("unknown op", r, 32'h0);
    endtask
    task automatic s_pack();
        logic [31:0] r;
        logic [31:0] b;
        logic [63:0] t;
        for (int s = 0; s < 32; s++) begin
            for (int j = 0; j < 2; j++) begin
                b = (j == 0) ? 32'h8765_4321 : 32'h4765_C321;
                run(SSP_PKBT, 32'h1234_5678, b, 5'(s), 2'h0, r);
                t = {32'h0, b} << s;
                chk("pack_bt", r, {t[31:16], 16'h5678});
                run(SSP_PKTB, 32'h1234_5678, b, 5'(s), 2'h0, r);
                t = {{32{b[31]}}, b};
                t = $signed(t) >>> (s == 0 ? 32 : s);
                chk("pack_tb", r, {16'h1234, t[15:0]});
            end
        end
    endtask
    task automatic s_ext();
        logic [31:0] r;
        logic [31:0] v;
        logic [31:0] e;
        for (int k = 0; k < 4; k++) begin
            v = 32'({32'h80F7_7F01, 32'h80F7_7F01} >> (8 * k));
            for (int o = SSP_SXB; o <= SSP_UXB16; o++) begin
                case (o)
                    SSP_SXB: e = {{24{v[7]}}, v[7:0]};
                    SSP_UXB: e = {24'h0, v[7:0]};
                    SSP_SXH: e = {{16{v[15]}}, v[15:0]};
                    SSP_UXH: e = {16'h0, v[15:0]};
                    SSP_SXB16: e = {{8{v[23]}}, v[23:16], {8{v[7]}}, v[7:0]};
                    default: e = {8'h0, v[23:16], 8'h0, v[7:0]};
                endcase
                run(ssp_op_t'(o), 32'hFFFF_FFFF, 32'h80F7_7F01, 5'h0, 2'(k), r);
                chk("extend", r, e);
            end
        end
    endtask
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        chk("reset result", o_result, 32'h0);
        chk("reset valid", {31'h0, o_valid}, 32'h0);
        chk("reset dest", {28'h0, o_dest_reg}, 32'h0);
        chk("reset flags", {28'h0, o_flags}, 32'h0);
        s_sat();
        s_pack();
        s_ext();
        final_report();
    end
endmodule
`default_nettype wire
